// file: core/cth_params.svh
// constants for the coprocessor transfer handshake sequencer
`ifndef CTH_PARAMS_SVH
`define CTH_PARAMS_SVH
`define CTH_FETCH_OFS   32'h0000_0008
`define CTH_DATA_OFS    32'h0000_000C
`define CTH_WORD_STEP   32'h0000_0004
`define CTH_SETTLE_CYCLES 4'h5
`endif

// file: core/cth_pkg.sv
// types for the coprocessor transfer handshake sequencer
package cth_pkg;
    typedef enum logic [1:0]
    {
        CTH_OP_TO_MEM = 2'h0,
        CTH_OP_LOAD   = 2'h1,
        CTH_OP_STORE  = 2'h2
    } cth_op_t;

    // one memory bus cycle as presented by the core
    typedef struct packed
    {
        logic [31:0] addr;
        logic        write;
        logic        mem_request_n;
        logic        sequential_cycle;
        logic        opcode_fetch_n;
        logic        coproc_instr_strobe_n;
        logic        data_oe;
    } cth_bus_t;
endpackage

// file: core/cth_sync.sv
// three-stage synchroniser for the handshake lines
`timescale 1ns/10ps
module cth_sync
    import cth_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // pulled-up lines read high from reset onward
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s1_reg  <= 1'b1;
            s2_reg  <= 1'b1;
            s3_reg  <= 1'b1;
            o_level <= 1'b1;
        end
        else
        begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
            begin
                o_level <= s3_reg;
            end
        end
    end
endmodule

// file: core/cth_core.sv
// coprocessor transfer handshake sequencer
`timescale 1ns/10ps
`include "cth_params.svh"
// Operation
// RULE1: a transfer to memory fetches at pc+8 with both strobes low, then writes words at an advancing address.
// RULE2: the coprocessor holds both lines low while words follow and releases both high on the last.
// RULE3: a coprocessor not yet committed holds absent low and busy high, and the core waits for busy low.
// RULE4: busy-wait cycles hold pc+8 with no memory request and no fetch while the strobe stays low.
// RULE5: a load from the coprocessor moves exactly one word and never continues.
// RULE6: a load writes the destination register in the third cycle after any wait.
// RULE7: the register-writing third cycle may merge with the next prefetch as one non-sequential cycle.
// RULE8: the load data cycle shows pc+12, read, no request, strobe high, and the coprocessor drives data.
// RULE9: a store follows the load sequence but drops the register-writing cycle.
// RULE10: the store data cycle drives the source value as a sequential write at pc+12 and prefetches on; the code goes to ST_IDLE after it with no memory request.
// RULE11: a coprocessor that cannot execute an instruction leaves both lines undriven.
// RULE12: both lines high after the offer take the undefined instruction trap.
// RULE13: pull-ups keep both lines high when nobody drives them.
module cth_core
    import cth_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire cth_op_t     i_op,
    input  wire logic [31:0] i_pc,
    input  wire logic [31:0] i_xfer_addr,
    input  wire logic [31:0] i_src_value,
    input  wire logic [31:0] i_bus_data_in,
    input  wire logic        i_coproc_absent,
    input  wire logic        i_coproc_busy,
    output cth_bus_t         o_bus,
    output logic [31:0]      o_bus_data_out,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_undef_trap,
    output logic             o_reg_we,
    output logic [31:0]      o_reg_wdata
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [5:0]
    {
        ST_IDLE  = 6'b00_0001,
        ST_OFFER = 6'b00_0010,
        ST_WAIT  = 6'b00_0100,
        ST_XFER  = 6'b00_1000,
        ST_DATA  = 6'b01_0000,
        ST_WRITE = 6'b10_0000
    } cth_state_t;

    cth_state_t  state_reg;
    cth_op_t     op_reg;
    logic [31:0] pc_reg;
    logic [31:0] addr_reg;
    logic [31:0] src_reg;
    logic        absent_s;
    logic        busy_s;
    logic [3:0]  settle_reg;

    function automatic cth_bus_t bus_cycle(input logic [31:0] a, input logic w,
                                           input logic mr_n, input logic sq,
                                           input logic opc_n, input logic cpi_n);
        cth_bus_t b;
        b.addr                  = a;
        b.write                 = w;
        b.mem_request_n         = mr_n;
        b.sequential_cycle      = sq;
        b.opcode_fetch_n        = opc_n;
        b.coproc_instr_strobe_n = cpi_n;
        b.data_oe               = 1'b0;
        return b;
    endfunction

    // both lines are pulled high when undriven, so reset state reads high
    cth_sync u_sync_absent (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_coproc_absent),
                            .o_level(absent_s)); // RULE13
    cth_sync u_sync_busy   (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_coproc_busy),
                            .o_level(busy_s)); // RULE13

    // an answer to the offer needs time to cross the synchronisers before it is trusted
    wire logic judge     = (settle_reg == 4'h0); // RULE12
    wire logic absent_hi = judge & absent_s & busy_s;
    wire logic commit    = judge & ~busy_s & ~absent_s;
    wire logic last_word = absent_s & busy_s;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_reg <= ST_IDLE;
            op_reg    <= CTH_OP_TO_MEM;
            pc_reg    <= 32'h0000_0000;
            addr_reg  <= 32'h0000_0000;
            src_reg   <= 32'h0000_0000;
            settle_reg <= 4'h0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (i_start)
                    begin
                        state_reg <= ST_OFFER;
                        op_reg    <= i_op;
                        pc_reg    <= i_pc;
                        addr_reg  <= i_xfer_addr;
                        src_reg   <= i_src_value;
                        settle_reg <= `CTH_SETTLE_CYCLES;
                    end
                end
                ST_OFFER, ST_WAIT:
                begin
                    settle_reg <= judge ? 4'h0 : settle_reg - 4'h1;
                    if (absent_hi)
                    begin
                        state_reg <= ST_IDLE; // RULE12 RULE11
                    end
                    else if (commit)
                    begin
                        state_reg <= (op_reg == CTH_OP_TO_MEM) ? ST_XFER : ST_DATA;
                    end
                    else
                    begin
                        state_reg <= ST_WAIT; // RULE3
                    end
                end
                ST_XFER:
                begin
                    addr_reg <= addr_reg + `CTH_WORD_STEP; // RULE1
                    if (last_word)
                    begin
                        state_reg <= ST_IDLE; // RULE2
                    end
                end
                ST_DATA:
                begin
                    // one word only, store skips the write cycle
                    state_reg <= (op_reg == CTH_OP_LOAD) ? ST_WRITE : ST_IDLE; // RULE5 RULE9
                end
                ST_WRITE:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bus outputs, registered from the next state
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_bus          <= bus_cycle(32'h0000_0000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
            o_bus_data_out <= 32'h0000_0000;
        end
        else
        begin
            o_bus_data_out <= 32'h0000_0000;
            o_bus          <= bus_cycle(pc_reg, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
            if (state_reg == ST_IDLE && i_start)
            begin
                // offer: fetch at pc+8, strobe low
                o_bus <= bus_cycle(i_pc + `CTH_FETCH_OFS, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0); // RULE1
            end
            else if ((state_reg == ST_OFFER || state_reg == ST_WAIT) && !absent_hi)
            begin
                if (!commit)
                begin
                    o_bus <= bus_cycle(pc_reg + `CTH_FETCH_OFS, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0); // RULE4
                end
                else if (op_reg == CTH_OP_TO_MEM)
                begin
                    o_bus <= bus_cycle(addr_reg, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1); // RULE1
                end
                else if (op_reg == CTH_OP_LOAD)
                begin
                    o_bus <= bus_cycle(pc_reg + `CTH_DATA_OFS, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1); // RULE8
                end
                else
                begin
                    o_bus          <= bus_cycle(pc_reg + `CTH_DATA_OFS, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1); // RULE10
                    o_bus.data_oe  <= 1'b1;
                    o_bus_data_out <= src_reg; // RULE10
                end
            end
            else if (state_reg == ST_XFER && !last_word)
            begin
                o_bus <= bus_cycle(addr_reg + `CTH_WORD_STEP, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
            end
            else if (state_reg == ST_DATA && op_reg == CTH_OP_LOAD)
            begin
                // write-back cycle merged with the next prefetch at pc+12
                o_bus <= bus_cycle(pc_reg + `CTH_DATA_OFS, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1); // RULE7
            end
        end
    end

    // ----------------------------------------------------------------
    // results
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_busy       <= 1'b0;
            o_done       <= 1'b0;
            o_undef_trap <= 1'b0;
            o_reg_we     <= 1'b0;
            o_reg_wdata  <= 32'h0000_0000;
        end
        else
        begin
            o_busy       <= (state_reg != ST_IDLE) || i_start;
            o_undef_trap <= (state_reg == ST_OFFER || state_reg == ST_WAIT) && absent_hi; // RULE12
            o_done       <= (state_reg == ST_XFER && last_word) ||
                            (state_reg == ST_DATA && op_reg == CTH_OP_STORE) ||
                            (state_reg == ST_WRITE);
            // data captured in the data cycle, written in the third cycle
            if (state_reg == ST_DATA && op_reg == CTH_OP_LOAD)
            begin
                o_reg_wdata <= i_bus_data_in; // RULE8
            end
            o_reg_we <= (state_reg == ST_DATA) && (op_reg == CTH_OP_LOAD); // RULE6
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_data_cycle;
        state_reg == ST_DATA;
    endsequence

    property p_load_one_word;
        @(posedge i_clk) disable iff (i_rst)
        (s_data_cycle and op_reg == CTH_OP_LOAD) |=> state_reg == ST_WRITE ##1 state_reg == ST_IDLE;
    endproperty
    a_load_one_word: assert property (p_load_one_word) else $error("load continued"); // RULE5

    property p_reg_write_third;
        @(posedge i_clk) disable iff (i_rst)
        o_reg_we |-> $past(state_reg) == ST_DATA && $past(op_reg) == CTH_OP_LOAD;
    endproperty
    a_reg_write_third: assert property (p_reg_write_third) else $error("bad write cycle"); // RULE6

    property p_store_no_write;
        @(posedge i_clk) disable iff (i_rst)
        (s_data_cycle and op_reg == CTH_OP_STORE) |=> state_reg == ST_IDLE && !o_reg_we;
    endproperty
    a_store_no_write: assert property (p_store_no_write) else $error("store wrote"); // RULE9

    property p_wait_bus;
        @(posedge i_clk) disable iff (i_rst)
        state_reg == ST_WAIT |-> o_bus.mem_request_n && o_bus.opcode_fetch_n &&
                                 !o_bus.coproc_instr_strobe_n &&
                                 o_bus.addr == pc_reg + `CTH_FETCH_OFS;
    endproperty
    a_wait_bus: assert property (p_wait_bus) else $error("busy-wait bus wrong"); // RULE4

    property p_load_data_bus;
        @(posedge i_clk) disable iff (i_rst)
        (s_data_cycle and op_reg == CTH_OP_LOAD) |-> o_bus.mem_request_n && !o_bus.write &&
            o_bus.coproc_instr_strobe_n && o_bus.addr == pc_reg + `CTH_DATA_OFS;
    endproperty
    a_load_data_bus: assert property (p_load_data_bus) else $error("load data bus wrong"); // RULE8

    property p_store_data_bus;
        @(posedge i_clk) disable iff (i_rst)
        (s_data_cycle and op_reg == CTH_OP_STORE) |-> !o_bus.mem_request_n && o_bus.write &&
            o_bus.sequential_cycle && o_bus_data_out == src_reg;
    endproperty
    a_store_data_bus: assert property (p_store_data_bus) else $error("store data bus wrong"); // RULE10

    property p_trap;
        @(posedge i_clk) disable iff (i_rst)
        ((state_reg == ST_OFFER || state_reg == ST_WAIT) && absent_hi) |=>
            o_undef_trap && state_reg == ST_IDLE;
    endproperty
    a_trap: assert property (p_trap) else $error("trap not taken"); // RULE12

    property p_offer;
        @(posedge i_clk) disable iff (i_rst)
        (state_reg == ST_IDLE && i_start) |=> !o_bus.opcode_fetch_n &&
            !o_bus.coproc_instr_strobe_n && o_bus.addr == pc_reg + `CTH_FETCH_OFS;
    endproperty
    a_offer: assert property (p_offer) else $error("offer cycle wrong"); // RULE1

    property p_xfer_advance;
        @(posedge i_clk) disable iff (i_rst)
        (state_reg == ST_XFER && !last_word) |=> addr_reg == $past(addr_reg) + `CTH_WORD_STEP;
    endproperty
    a_xfer_advance: assert property (p_xfer_advance) else $error("address not advanced"); // RULE1
endmodule

// file: dv/cth_coproc_model.sv
// behavioural coprocessor on the far side of the handshake lines
`timescale 1ns/10ps
module cth_coproc_model
    import cth_pkg::*;
(
    input  wire logic        i_clk,
    input  wire cth_bus_t    i_bus,
    input  wire logic        i_present,
    input  wire logic [7:0]  i_wait,
    input  wire logic [7:0]  i_words,
    input  wire logic [31:0] i_word,
    input  wire logic        i_to_mem,
    output logic             o_coproc_absent,
    output logic             o_coproc_busy,
    output logic [31:0]      o_data
);
    logic [1:0] st_reg;
    logic [7:0] cnt_reg;
    logic [7:0] seen_reg;
    initial
    begin
        st_reg   = 2'h0;
        cnt_reg  = 8'h00;
        seen_reg = 8'h00;
    end
    // idle or refusing: lines undriven, so the pull-ups read high
    assign o_coproc_absent = (st_reg == 2'h0);
    assign o_coproc_busy   = (st_reg != 2'h2);
    // a released bus shows the inverse so a stale word cannot pass
    assign o_data = (st_reg == 2'h2) ? i_word : ~i_word;
    always @(posedge i_clk)
    begin
        case (st_reg)
            2'h0:
            begin
                seen_reg <= 8'h00;
                cnt_reg  <= i_wait;
                if (i_present && !i_bus.coproc_instr_strobe_n && !i_bus.opcode_fetch_n)
                    st_reg <= 2'h1;
            end
            2'h1:
            begin
                cnt_reg <= cnt_reg - 8'h01;
                if (cnt_reg == 8'h00)
                    st_reg <= 2'h2;
            end
            default:
            begin
                // both lines go high for the final transfer cycle
                // the lines cross the core's synchronisers, so a memory transfer ends by
                // counting cycles after commit; a register transfer ends on its data cycle
                seen_reg <= seen_reg + 8'h01;
                if (i_to_mem ? (seen_reg + 8'h01 >= i_words) : i_bus.coproc_instr_strobe_n)
                    st_reg <= 2'h0;
            end
        endcase
    end
endmodule

// file: dv/coproc_transfer_handshake_tb.sv
// self-checking bench for the coprocessor transfer handshake sequencer
`timescale 1ns/10ps
module coproc_transfer_handshake_tb;
    import cth_pkg::*;
    logic        i_clk, i_rst, i_start, pres;
    cth_op_t     i_op;
    logic [31:0] i_pc, i_xfer_addr, i_src_value, dat, word, wd, exp_wr;
    logic        coproc_absent, coproc_busy, done, trap, we, busy, tm;
    logic [7:0]  wt, nw;
    cth_bus_t    b;
    logic [31:0] dout;
    int err_total, compares, n_off, n_wait, bad_wait, n_wr, bad_wr, n_ld, n_mrg, n_we, n_trap;
    cth_core cth_core_inst (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_op(i_op),
        .i_pc(i_pc), .i_xfer_addr(i_xfer_addr), .i_src_value(i_src_value),
        .i_bus_data_in(dat), .i_coproc_absent(coproc_absent), .i_coproc_busy(coproc_busy), .o_bus(b),
        .o_bus_data_out(dout), .o_busy(busy), .o_done(done), .o_undef_trap(trap),
        .o_reg_we(we), .o_reg_wdata(wd));
    cth_coproc_model cth_coproc_model_inst (.i_clk(i_clk), .i_bus(b), .i_present(pres),
        .i_wait(wt), .i_words(nw), .i_word(word), .i_to_mem(tm), .o_coproc_absent(coproc_absent),
        .o_coproc_busy(coproc_busy), .o_data(dat));
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // ---------------------------------------------------------------
    // bus monitor, sampled mid-cycle where outputs have settled
    // ---------------------------------------------------------------
    always @(negedge i_clk)
    begin
        if (!i_rst)
        begin
            if (!b.coproc_instr_strobe_n && !b.opcode_fetch_n && b.addr === i_pc + 32'h0000_0008)
                n_off++;
            if (!b.coproc_instr_strobe_n && b.opcode_fetch_n)
            begin
                n_wait++;
                if (b.addr !== i_pc + 32'h0000_0008 || b.mem_request_n !== 1'b1)
                    bad_wait++;
            end
            if (b.write === 1'b1 && b.mem_request_n === 1'b0)
            begin
                n_wr++;
                if (b.addr !== exp_wr)
                    bad_wr++;
                if (i_op == CTH_OP_STORE && (dout !== i_src_value || b.data_oe !== 1'b1
                    || b.sequential_cycle !== 1'b1))
                    bad_wr++;
                exp_wr = exp_wr + 32'h0000_0004;
            end
            if (b.coproc_instr_strobe_n && b.opcode_fetch_n && b.write === 1'b0
                && b.mem_request_n && b.addr === i_pc + 32'h0000_000C)
                n_ld++;
            if (b.write === 1'b0 && b.mem_request_n === 1'b0 && b.sequential_cycle === 1'b0
                && b.addr === i_pc + 32'h0000_000C)
                n_mrg++;
            if (we === 1'b1)
                n_we++;
            if (trap === 1'b1)
                n_trap++;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one complete operation, ended by done or trap under a bound
    task automatic run(input cth_op_t op, input logic [7:0] w, input logic [7:0] n,
        input logic p);
        int k;
        @(posedge i_clk);
        {n_off, n_wait, bad_wait, n_wr, bad_wr, n_ld, n_mrg, n_we, n_trap} = '0;
        i_op        <= op;
        i_pc        <= i_pc + 32'h0000_1000;
        i_xfer_addr <= i_xfer_addr + 32'h0000_0100;
        i_src_value <= ~i_src_value;
        word        <= word + 32'h0101_0101;
        wt <= w;
        nw <= n;
        pres <= p;
        tm   <= (op == CTH_OP_TO_MEM);
        i_start <= 1'b1;
        exp_wr = (op == CTH_OP_STORE) ? i_pc + 32'h0000_100C : i_xfer_addr + 32'h0000_0100;
        @(posedge i_clk);
        i_start <= 1'b0;
        @(negedge i_clk);
        chk("busy", 32'h1, {31'h0, busy});
        for (k = 0; k < 200 && done !== 1'b1 && trap !== 1'b1; k++)
            @(negedge i_clk);
        chk("finished", 32'h1, {31'h0, k < 200});
        repeat (3) @(negedge i_clk);
        chk("idle", 32'h0, {31'h0, busy});
    endtask
    task automatic to_mem_test(input logic [7:0] w);
        run(CTH_OP_TO_MEM, w, 8'h03, 1'b1);
        chk("offer", 32'h1, n_off);
        chk("word count", 32'h3, n_wr);
        chk("word addresses", 32'h0, bad_wr);
        chk("wait shape", 32'h0, bad_wait);
        chk("wait length", 32'h1, {31'h0, n_wait >= w});
        $display("test to_mem wait %0d done", w);
    endtask
    task automatic load_test(input logic [7:0] w);
        run(CTH_OP_LOAD, w, 8'h01, 1'b1);
        chk("load data cycles", 32'h1, n_ld);
        chk("reg writes", 32'h1, n_we);
        chk("reg value", word, wd);
        chk("merged cycle", 32'h1, n_mrg);
        chk("load writes", 32'h0, n_wr);
        chk("wait shape", 32'h0, bad_wait);
        chk("wait length", 32'h1, {31'h0, n_wait >= w});
        $display("test load wait %0d done", w);
    endtask
    task automatic store_test(input logic [7:0] w);
        run(CTH_OP_STORE, w, 8'h01, 1'b1);
        chk("store writes", 32'h1, n_wr);
        chk("store bus", 32'h0, bad_wr);
        chk("store reg writes", 32'h0, n_we);
        chk("store merged", 32'h0, n_mrg);
        $display("test store wait %0d done", w);
    endtask
    task automatic absent_test();
        run(CTH_OP_LOAD, 8'h00, 8'h01, 1'b0);
        chk("trap", 32'h1, n_trap);
        chk("absent reg writes", 32'h0, n_we);
        chk("absent data", 32'h0, n_ld + n_wr);
        $display("test absent done");
    endtask
    initial
    begin
        {err_total, compares} = '0;
        i_rst = 1'b1;
        i_start = 1'b0;
        i_op = CTH_OP_TO_MEM;
        i_pc = 32'h0000_0000;
        i_xfer_addr = 32'h0000_4000;
        i_src_value = 32'h5A5A_C3C3;
        word = 32'h1234_5678;
        exp_wr = 32'h0000_0000;
        pres = 1'b1;
        tm = 1'b0;
        wt = 8'h00;
        nw = 8'h01;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        to_mem_test(8'h00);
        to_mem_test(8'h04);
        load_test(8'h00);
        load_test(8'h06);
        store_test(8'h03);
        load_test(8'h01);
        absent_test();
        store_test(8'h00);
        report_and_stop();
    end
    // the whole sequence needs well under two hundred cycles
    initial
    begin
        #100000;
        err_total++;
        report_and_stop();
    end
endmodule
